// ---- cba_arbiter.sv ----
// Cluster bus arbiter: request lines, host grant, priority access, lock
//
// Added by the designer: the address map and register access over AHB-Lite.
module cba_arbiter import cba_pkg::*; #(
	parameter int NUM_PROC = CBA_NUM_PROC,
	parameter int TL_W = CBA_TL_W
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic [CBA_ID_W-1:0] i_processor_identity,
	input wire logic i_core_req,
	input wire logic i_dma_hi_req,
	input wire logic i_dma_req,
	input wire logic i_xact_busy,
	output logic o_bus_owned,
	input wire logic [CBA_NUM_PROC-1:0] i_mreq_line_n,
	output logic [CBA_NUM_PROC-1:0] o_mreq_line_o,
	output logic [CBA_NUM_PROC-1:0] o_mreq_line_oe_n,
	input wire logic i_core_prio_line_n,
	output logic o_core_prio_line_o,
	output logic o_core_prio_line_oe_n,
	input wire logic i_dma_prio_line_n,
	output logic o_dma_prio_line_o,
	output logic o_dma_prio_line_oe_n,
	input wire logic i_host_request_n,
	input wire logic i_host_yield_n,
	input wire logic i_host_grant_n,
	output logic o_host_grant_o,
	output logic o_host_grant_oe_n,
	output logic o_atomic_hold_ind_n
);
	// ============================================================
	// Helpers
	function automatic logic [CBA_NUM_PROC-1:0] id_onehot(
		input logic [CBA_ID_W-1:0] id);
		id_onehot = '0;
		id_onehot[id] = 1'b1;
	endfunction : id_onehot

	// First requester above cur, wrapping: the old master ends up last
	function automatic logic [CBA_ID_W:0] pick_next(
		input logic [CBA_NUM_PROC-1:0] req,
		input logic [CBA_ID_W-1:0] cur);
		logic [CBA_ID_W-1:0] idx;
		pick_next = '0;
		for (int k = 1; k <= CBA_NUM_PROC; k++) begin
			idx = cur + CBA_ID_W'(k);
			if (req[idx] && !pick_next[CBA_ID_W])
				pick_next = {1'b1, idx};
		end
	endfunction : pick_next

	// ============================================================
	// Pin synchroniser
	cba_pins_t pins_raw;
	cba_pins_t pins_s1;
	cba_pins_t pins;
	assign pins_raw = {~i_mreq_line_n, ~i_core_prio_line_n,
		~i_dma_prio_line_n, ~i_host_request_n, ~i_host_yield_n,
		~i_host_grant_n, i_processor_identity};
	always_ff @(posedge i_clk_sys) begin
		pins_s1 <= pins_raw;
		pins <= pins_s1;
	end

	// ============================================================
	// Register file
	logic lock_bit;
	logic [TL_W-1:0] tlim;
	logic wr_pend;
	logic [7:0] wr_ofs;
	logic addr_ok;
	cba_status_t status;
	assign addr_ok = i_hsel && i_htrans[1] && i_hready;
	assign o_hreadyout = 1'b1;
	assign o_hresp = CBA_RESP_OKAY[0];

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			wr_pend <= 1'b0;
			wr_ofs <= CBA_OFS_CTRL;
		end else begin
			wr_pend <= addr_ok && i_hwrite;
			wr_ofs <= i_haddr[7:0];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			lock_bit <= CBA_LOCK_RST;
			tlim <= CBA_TLIM_RST;
		end else if (wr_pend) begin
			if (wr_ofs == CBA_OFS_CTRL)
				lock_bit <= i_hwdata[CBA_CTRL_LOCK_BIT];
			if (wr_ofs == CBA_OFS_TLIM)
				tlim <= i_hwdata[TL_W-1:0];
		end
	end

	// Unmapped offsets read as zero with an OKAY answer
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_hrdata <= CBA_ZERO_WORD;
		end else if (addr_ok && !i_hwrite) begin
			case (i_haddr[7:0])
				CBA_OFS_CTRL: o_hrdata <= 32'(lock_bit);
				CBA_OFS_TLIM: o_hrdata <= 32'(tlim);
				CBA_OFS_STAT: o_hrdata <= 32'(status);
				default: o_hrdata <= CBA_ZERO_WORD;
			endcase
		end
	end

	// ============================================================
	// Shared bus tracking, identical in every arbiter
	cba_state_t st;
	logic [CBA_ID_W-1:0] master;
	logic [CBA_ID_W:0] winner;
	logic [CBA_NUM_PROC-1:0] my_bit;
	logic is_master;
	logic others_req;
	assign my_bit = id_onehot(pins.id);
	assign winner = pick_next(pins.req, master);
	assign is_master = (st == CBA_ST_OWNED) && (master == pins.id);
	assign others_req = |(pins.req & ~my_bit);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st <= CBA_ST_OWNED;
			master <= CBA_RST_MASTER;
		end else begin
			case (st)
				CBA_ST_OWNED: begin
					if (pins.host_grant)
						st <= CBA_ST_HOST;
					else if (!pins.req[master] && |pins.req)
						st <= CBA_ST_GAP;
				end
				CBA_ST_GAP: begin
					st <= CBA_ST_OWNED;
					if (winner[CBA_ID_W])
						master <= winner[CBA_ID_W-1:0];
				end
				CBA_ST_HOST: begin
					if (!pins.host_grant)
						st <= CBA_ST_OWNED;
				end
				default: st <= CBA_ST_OWNED;
			endcase
		end
	end

	// ============================================================
	// Time limit
	logic [TL_W-1:0] tl_cnt;
	logic expired;
	logic was_master;
	logic release_now;
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			was_master <= 1'b0;
		else
			was_master <= is_master || (st == CBA_ST_HOST && was_master);
	end

	// Zero limit disables the fairness check
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			tl_cnt <= CBA_TLIM_RST;
			expired <= 1'b0;
		end else if (is_master && !was_master) begin
			tl_cnt <= tlim;
			expired <= 1'b0;
		end else if (is_master && tlim != '0) begin
			if (tl_cnt != '0) begin
				tl_cnt <= tl_cnt - TL_W'(1);
			end else if (lock_bit) begin
				expired <= 1'b1;
			end else if (!others_req) begin
				tl_cnt <= tlim;
				expired <= 1'b0;
			end else begin
				expired <= 1'b1;
			end
		end else if (!is_master && st != CBA_ST_HOST) begin
			expired <= 1'b0;
		end
	end

	// Release stops driving the request line low until the state leaves CBA_ST_OWNED
	assign release_now = is_master && expired && !lock_bit && others_req
		&& !i_xact_busy && !(tl_cnt != '0);

	// ============================================================
	// Request, priority lines and host grant
	logic drv_req;
	logic drv_cpa;
	logic drv_dpa;
	logic drv_grant;
	logic [CBA_DRV_DLY-1:0] cpa_hist;
	logic cpa_other;
	logic want;
	logic eligible;
	logic next_req;
	logic next_grant;
	assign cpa_other = pins.prio.core && !cpa_hist[CBA_DRV_DLY-1];
	assign want = lock_bit || i_core_req || i_dma_hi_req || i_dma_req;
	assign eligible = lock_bit || i_core_req
		|| (i_dma_hi_req && !pins.prio.core)
		|| (i_dma_req && !pins.prio.core && !pins.prio.dma);

	always_comb begin
		next_req = want && eligible;
		if (is_master && i_xact_busy)
			next_req = 1'b1;
		if (st == CBA_ST_HOST && was_master)
			next_req = 1'b1;
		if (release_now)
			next_req = 1'b0;
	end

	// Lock keeps the grant back unless the host also asserts yield
	always_comb begin
		next_grant = 1'b0;
		if (pins.host_req && (is_master || (drv_grant && was_master)))
			next_grant = (!lock_bit || pins.host_yield)
				&& (!i_xact_busy || pins.host_yield || drv_grant);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			drv_req <= 1'b0;
			drv_cpa <= 1'b0;
			drv_dpa <= 1'b0;
			drv_grant <= 1'b0;
			cpa_hist <= '0;
		end else begin
			drv_req <= next_req;
			drv_cpa <= i_core_req;
			drv_dpa <= i_dma_hi_req && !i_core_req && !cpa_other;
			drv_grant <= next_grant;
			cpa_hist <= {cpa_hist[CBA_DRV_DLY-2:0], drv_cpa};
		end
	end

	genvar g;
	generate
		for (g = 0; g < CBA_NUM_PROC; g++) begin : g_line
			assign o_mreq_line_o[g] = CBA_LINE_LOW;
			assign o_mreq_line_oe_n[g] = ~(drv_req && my_bit[g]);
		end
	endgenerate
	assign o_core_prio_line_o = CBA_LINE_LOW;
	assign o_core_prio_line_oe_n = ~drv_cpa;
	assign o_dma_prio_line_o = CBA_LINE_LOW;
	assign o_dma_prio_line_oe_n = ~drv_dpa;
	assign o_host_grant_o = CBA_LINE_LOW;
	assign o_host_grant_oe_n = ~drv_grant;

	// ============================================================
	// Indicators and status
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_bus_owned <= 1'b0;
			o_atomic_hold_ind_n <= 1'b1;
		end else begin
			o_bus_owned <= is_master;
			o_atomic_hold_ind_n <= ~(lock_bit && is_master);
		end
	end
	assign status = '{cur_master: master, host_owned: st == CBA_ST_HOST,
		is_master: is_master, locked: ~o_atomic_hold_ind_n,
		expired: expired};

	// ============================================================
	// Assertions
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	sequence s_master_drops;
		st == CBA_ST_OWNED && !pins.req[master] && |pins.req
			&& !pins.host_grant;
	endsequence
	sequence s_gap_then_own;
		st == CBA_ST_GAP ##1 st == CBA_ST_OWNED;
	endsequence

	property p_handover;
		s_master_drops |=> s_gap_then_own;
	endproperty
	a_handover: assert property (p_handover)
		else $error("handover skipped the idle cycle");

	property p_new_master;
		s_master_drops ##1 st == CBA_ST_GAP && winner[CBA_ID_W]
			|=> master == $past(winner[CBA_ID_W-1:0]);
	endproperty
	a_new_master: assert property (p_new_master)
		else $error("winner not made master");

	property p_one_line;
		$onehot0(~o_mreq_line_oe_n);
	endproperty
	a_one_line: assert property (p_one_line)
		else $error("more than one request line driven");

	property p_reset_master;
		$past(i_sys_rst) |-> master == CBA_RST_MASTER;
	endproperty
	a_reset_master: assert property (p_reset_master)
		else $error("master after reset not zero");

	property p_lock_req;
		lock_bit && !release_now |=> !o_mreq_line_oe_n[pins.id];
	endproperty
	a_lock_req: assert property (p_lock_req)
		else $error("lock bit did not hold request");

	property p_lock_grant;
		lock_bit && pins.host_req && !pins.host_yield |=> !drv_grant;
	endproperty
	a_lock_grant: assert property (p_lock_grant)
		else $error("grant given under lock without yield");

	property p_lock_ind;
		!o_atomic_hold_ind_n |-> $past(lock_bit) && $past(is_master);
	endproperty
	a_lock_ind: assert property (p_lock_ind)
		else $error("lock indicator without locked mastership");

	property p_core_drop;
		pins.prio.core && !i_core_req && !lock_bit && !is_master
			&& !(st == CBA_ST_HOST) |=> !drv_req;
	endproperty
	a_core_drop: assert property (p_core_drop)
		else $error("non-core request held under core priority");

	property p_tl_pause;
		st == CBA_ST_HOST |=> tl_cnt == $past(tl_cnt);
	endproperty
	a_tl_pause: assert property (p_tl_pause)
		else $error("time limit counted under host grant");

	property p_release;
		release_now |=> !drv_req ##2 !pins.req[pins.id];
	endproperty
	a_release: assert property (p_release)
		else $error("expiry release did not drop the line");
endmodule : cba_arbiter

// ---- cba_pkg.sv ----
// Constants, types and register map of the cluster bus arbiter
package cba_pkg;
	localparam int CBA_NUM_PROC = 8;
	localparam int CBA_ID_W = 3;
	localparam int CBA_TL_W = 16;
	localparam int CBA_SYNC_W = 16;
	// ============================================================
	// Register map (byte addresses)
	localparam logic [7:0] CBA_OFS_CTRL = 8'h00;
	localparam logic [7:0] CBA_OFS_TLIM = 8'h04;
	localparam logic [7:0] CBA_OFS_STAT = 8'h08;
	localparam int CBA_CTRL_LOCK_BIT = 0;
	localparam logic CBA_LOCK_RST = 1'b0;
	localparam logic [CBA_TL_W-1:0] CBA_TLIM_RST = 16'h0000;
	localparam logic [CBA_ID_W-1:0] CBA_RST_MASTER = 3'h0;
	localparam logic [31:0] CBA_ZERO_WORD = 32'h0000_0000;
	localparam logic [1:0] CBA_RESP_OKAY = 2'h0;
	localparam logic CBA_LINE_LOW = 1'b0;
	// Drive history depth matching the two-stage pin synchroniser
	localparam int CBA_DRV_DLY = 2;
	// ============================================================
	// Types
	typedef enum logic [1:0] {
		CBA_ST_OWNED,
		CBA_ST_GAP,
		CBA_ST_HOST
	} cba_state_t;
	typedef struct packed {
		logic [CBA_ID_W-1:0] cur_master;
		logic host_owned;
		logic is_master;
		logic locked;
		logic expired;
	} cba_status_t;
	typedef struct packed {
		logic core;
		logic dma;
	} cba_prio_t;
	typedef struct packed {
		logic [CBA_NUM_PROC-1:0] req;
		cba_prio_t prio;
		logic host_req;
		logic host_yield;
		logic host_grant;
		logic [CBA_ID_W-1:0] id;
	} cba_pins_t;
endpackage : cba_pkg

// ---- cba_peers.sv ----
// Peer processors and host bridge on the shared cluster bus
module cba_peers (
	input wire logic i_clk_sys,
	input wire logic [7:0] i_peer_req,
	input wire logic i_peer_core,
	input wire logic i_host_req,
	input wire logic i_host_yield,
	input wire logic [7:0] i_dut_req_oe_n,
	input wire logic i_dut_core_oe_n,
	input wire logic i_dut_grant_oe_n,
	input wire logic i_peer_dma,
	input wire logic i_dut_dma_oe_n,
	output logic o_dma_n,
	output logic [7:0] o_req_n,
	output logic o_core_n,
	output logic o_host_req_n,
	output logic o_host_yield_n,
	output logic o_grant_n,
	output logic o_host_drive
);
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Wired lines
	// Low when any party pulls low; the pull-ups hold them high otherwise
	assign o_req_n = i_dut_req_oe_n & ~i_peer_req;
	assign o_core_n = i_dut_core_oe_n & ~i_peer_core;
	assign o_grant_n = i_dut_grant_oe_n;
	assign o_dma_n = i_dut_dma_oe_n & ~i_peer_dma;
	assign o_host_req_n = ~i_host_req;
	assign o_host_yield_n = ~i_host_yield;
	// ============================================================
	// Host bus drive
	// Drives only once grant is sampled, stops with its request
	always_ff @(posedge i_clk_sys) begin
		o_host_drive <= i_host_req & (~o_grant_n | o_host_drive);
	end
endmodule : cba_peers

// ---- cba_arbiter_tb.sv ----
// Self-checking bench of the cluster bus arbiter
module cba_arbiter_tb import cba_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hrdy;
	logic core_req = 1'b0;
	logic dma_req = 1'b0;
	logic owned;
	logic [7:0] req_oe_n;
	logic core_oe_n;
	logic dma_oe_n;
	logic grant_oe_n;
	logic ind_n;
	logic [7:0] req_n;
	logic core_n;
	logic hreq_n;
	logic hyld_n;
	logic grant_n;
	logic [7:0] peer_req = 8'h0;
	logic peer_core = 1'b0;
	logic host_req = 1'b0;
	logic host_yield = 1'b0;
	logic host_drv;
	logic hresp;
	logic [10:0] line_o;
	logic dma_hi = 1'b0;
	logic busy = 1'b0;
	logic peer_dma = 1'b0;
	logic dma_n;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	always #2 clk = ~clk;
	cba_arbiter u_cba_arbiter (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
		.o_hreadyout(hrdy), .o_hresp(hresp), .i_processor_identity(3'h0),
		.i_core_req(core_req), .i_dma_hi_req(dma_hi), .i_dma_req(dma_req),
		.i_xact_busy(busy), .o_bus_owned(owned), .i_mreq_line_n(req_n),
		.o_mreq_line_o(line_o[7:0]), .o_mreq_line_oe_n(req_oe_n),
		.i_core_prio_line_n(core_n), .o_core_prio_line_o(line_o[8]),
		.o_core_prio_line_oe_n(core_oe_n), .i_dma_prio_line_n(dma_n),
		.o_dma_prio_line_o(line_o[9]), .o_dma_prio_line_oe_n(dma_oe_n),
		.i_host_request_n(hreq_n), .i_host_yield_n(hyld_n),
		.i_host_grant_n(grant_n), .o_host_grant_o(line_o[10]),
		.o_host_grant_oe_n(grant_oe_n), .o_atomic_hold_ind_n(ind_n)
	);
	cba_peers u_cba_peers (
		.i_clk_sys(clk), .i_peer_req(peer_req), .i_peer_core(peer_core),
		.i_host_req(host_req), .i_host_yield(host_yield),
		.i_dut_req_oe_n(req_oe_n), .i_dut_core_oe_n(core_oe_n),
		.i_dut_grant_oe_n(grant_oe_n), .o_req_n(req_n), .o_core_n(core_n),
		.i_peer_dma(peer_dma), .i_dut_dma_oe_n(dma_oe_n), .o_dma_n(dma_n),
		.o_host_req_n(hreq_n), .o_host_yield_n(hyld_n),
		.o_grant_n(grant_n), .o_host_drive(host_drv)
	);
	// ============================================================
	// Tasks
	task automatic print_verdict();
		if (err_total == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Single word transfer; read data taken at the data phase edge
	task automatic ahb(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		r = hrdata;
		chk("hresp", {30'h0, CBA_RESP_OKAY}, {31'h0, hresp});
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e, input string nm);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		chk(nm, e, x & m);
	endtask : rdc
	function automatic logic sig(input int s);
		case (s)
			0: return owned;
			1: return grant_oe_n;
			2: return ind_n;
			4: return core_oe_n;
			5: return dma_oe_n;
			default: return req_oe_n[0];
		endcase
	endfunction : sig
	// Bounded wait for a design output to reach a level
	task automatic wt(input int s, input logic v, input string nm);
		logic g;
		for (int i = 0; i < 80; i++) begin
			@(posedge clk);
			g = sig(s);
			if (g === v) break;
		end
		chk(nm, {31'h0, v}, {31'h0, g});
	endtask : wt
	// ============================================================
	// Timeout
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	// ============================================================
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wt(0, 1'b1, "owned");
		chk("line out", 32'h0, {21'h0, line_o});
		rdc(CBA_OFS_STAT, 32'h7f, 32'h4, "stat");
		rdc(CBA_OFS_CTRL, 32'hffffffff, 32'h0, "ctrl");
		rdc(8'h0c, 32'hffffffff, 32'h0, "unmapped");
		wr(CBA_OFS_TLIM, 32'h1234);
		rdc(CBA_OFS_TLIM, 32'hffffffff, 32'h1234, "tlim");
		wr(CBA_OFS_TLIM, 32'h8);
		core_req <= 1'b1;
		wt(4, 1'b0, "core prio");
		core_req <= 1'b0;
		wt(4, 1'b1, "core prio off");
		host_req <= 1'b1;
		wt(1, 1'b0, "grant");
		repeat (4) @(posedge clk);
		chk("host line", 32'h0, {31'h0, req_oe_n[0]});
		chk("host drive", 32'h1, {31'h0, host_drv});
		host_req <= 1'b0;
		wt(1, 1'b1, "grant off");
		wt(0, 1'b1, "back");
		dma_req <= 1'b1;
		peer_req <= 8'h04;
		wt(0, 1'b0, "tl yield");
		rdc(CBA_OFS_STAT, 32'h70, 32'h20, "stat p2");
		wt(3, 1'b0, "loser line");
		peer_req <= 8'h00;
		wt(0, 1'b1, "regain");
		wr(CBA_OFS_TLIM, 32'h0);
		peer_req <= 8'h20;
		peer_core <= 1'b1;
		wt(0, 1'b0, "core yield");
		wt(3, 1'b1, "line drop");
		rdc(CBA_OFS_STAT, 32'h70, 32'h50, "stat p5");
		peer_req <= 8'h00;
		peer_core <= 1'b0;
		wt(0, 1'b1, "after prio");
		busy <= 1'b1;
		peer_req <= 8'h20;
		peer_dma <= 1'b1;
		repeat (10) @(posedge clk);
		chk("busy hold", 32'h1, {31'h0, owned});
		busy <= 1'b0;
		wt(0, 1'b0, "dpa yield");
		wt(3, 1'b1, "dpa line drop");
		peer_req <= 8'h00;
		peer_dma <= 1'b0;
		wt(0, 1'b1, "dpa regain");
		dma_hi <= 1'b1;
		wt(5, 1'b0, "dpa drive");
		peer_req <= 8'h20;
		peer_core <= 1'b1;
		wt(5, 1'b1, "dpa off");
		wt(0, 1'b0, "cpa over dpa");
		wt(3, 1'b1, "dpa req drop");
		peer_req <= 8'h00;
		peer_core <= 1'b0;
		wt(0, 1'b1, "cpa regain");
		dma_hi <= 1'b0;
		dma_req <= 1'b0;
		wr(CBA_OFS_CTRL, 32'h1);
		wt(2, 1'b0, "lock ind");
		wt(3, 1'b0, "lock line");
		peer_req <= 8'h20;
		peer_core <= 1'b1;
		host_req <= 1'b1;
		repeat (20) @(posedge clk);
		chk("locked owned", 32'h1, {31'h0, owned});
		chk("no grant", 32'h1, {31'h0, grant_oe_n});
		host_yield <= 1'b1;
		wt(1, 1'b0, "yield grant");
		host_req <= 1'b0;
		host_yield <= 1'b0;
		peer_req <= 8'h00;
		peer_core <= 1'b0;
		wt(0, 1'b1, "lock back");
		dma_req <= 1'b1;
		peer_req <= 8'h04;
		wr(CBA_OFS_TLIM, 32'h8);
		repeat (20) @(posedge clk);
		chk("expiry under lock", 32'h1, {31'h0, owned});
		wr(CBA_OFS_CTRL, 32'h0);
		wt(2, 1'b1, "unlock");
		wt(0, 1'b0, "unlock release");
		peer_req <= 8'h00;
		print_verdict();
	end
endmodule : cba_arbiter_tb
